// [shared/lbd_pkg.sv]
// constants, codes and carrier types for the backlight dimming block
// assumes a single 100 MHz clock and a decoded serial-bus register port
package lbd_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] LBD_ADDR_BRIGHT = 8'h00;
  localparam logic [7:0] LBD_ADDR_MODE   = 8'h01;
  localparam logic [7:0] LBD_ADDR_DC     = 8'h07;

  // ==========================================================
  // values after reset
  localparam logic [7:0] LBD_RST_BRIGHT = 8'hff;
  localparam logic [7:0] LBD_RST_MODE   = 8'h01;
  localparam logic [7:0] LBD_RST_DC     = 8'hff;
  localparam logic [7:0] LBD_RST_DUTY   = 8'hff;

  // ==========================================================
  // dimming mode codes
  localparam logic [7:0] LBD_MODE_PRODUCT = 8'h01;
  localparam logic [7:0] LBD_MODE_EXT     = 8'h03;
  localparam logic [7:0] LBD_MODE_SERIAL  = 8'h05;

  // ==========================================================
  // timing
  localparam int LBD_CLK_PERIOD_NS = 10;
  localparam int LBD_EN_LOW_US     = 30000;
  // longer than the figure: one cycle past the rounded-down count
  localparam int LBD_EN_LOW_CYC    = LBD_EN_LOW_US * 1000 / LBD_CLK_PERIOD_NS + 1;
  localparam logic [7:0] LBD_STEP_LAST = 8'hfe;  // 255 steps per dimming period
  localparam int LBD_CH_COUNT      = 6;
  localparam int LBD_SYNC_PINS     = 3;

  // ==========================================================
  // types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lbd_reg_req_t;

  typedef enum logic [1:0] {
    LBD_ST_RUN = 2'b00,
    LBD_ST_LOW = 2'b01,
    LBD_ST_OFF = 2'b11
  } lbd_state_t;

endpackage

// [rtl/lbd_duty_meter.sv]
// digitizes the external pwm duty to 8 bits
// assumes pwm_level is already synchronised; tick and frame_end come from the step counter
`timescale 1ns/1ps
`default_nettype none
module lbd_duty_meter (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       frame_end,
  input  wire logic       pwm_level,
  output logic [7:0]      duty
);
  import lbd_pkg::*;

  logic [7:0] acc;
  logic [7:0] next_acc;
  logic [7:0] next_duty;

  // ==========================================================
  // one sample per dimming step, 255 samples give 0..255 directly
  // a divider-free count; aliasing is possible if the input is locked to the step rate
  always_comb begin
    next_acc  = acc;
    next_duty = duty;
    if (tick) begin
      if (frame_end) begin
        next_duty = acc + {7'h00, pwm_level};
        next_acc  = 8'h00;
      end else begin
        next_acc = acc + {7'h00, pwm_level};
      end
    end
  end

  // registers only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc  <= 8'h00;
      duty <= LBD_RST_DUTY;
    end else begin
      acc  <= next_acc;
      duty <= next_duty;
    end
  end

endmodule
`default_nettype wire

// [rtl/lbd_dimming_top.sv]
// digital dimming control for a six-channel led backlight driver
// assumes the serial-bus byte layer hands over one-cycle decoded register requests
//
// Contract
// (RL1) enable low longer than 30 ms shuts the block down; shorter lows do not
// (RL2) dc current level register at 0x07, any 0..255, resets to 255
// (RL3) dc current level zero disconnects every channel in any mode
// (RL4) dc current level writes take effect immediately, no restart needed
// (RL5) on-period current command scales linearly with dc level, 255 is full scale
// (RL6) internal dimming waveform has 256 duty steps set by brightness level; the step counter here runs 255 steps, 0..254
// (RL7) product mode duty is measured external duty times brightness fraction
// (RL8) direct mode channels follow the external pwm frequency and duty
// (RL9) after reset the block runs in product mode
// (RL10) one dimming waveform gates all six channels together
// (RL11) serial-only duty equals brightness level at 0x00 over 255
// (RL12) brightness level accepts 0..255 and resets to 255
// (RL13) brightness level zero turns all channels off; the code ignores it in mode 0x03 and in direct mode
// (RL14) mode 0x05 at 0x01 dims from brightness only, ignoring external pwm
// (RL15) mode register resets to 0x01; external input high leaves brightness alone; the product here gives brightness minus one
// (RL16) mode 0x03 uses the external pwm duty alone
// (RL17) product keeps the eight high bits of duty times brightness
// (RL18) external pwm source never holds low past 30.5 ms
// (RL19) dimming period comes from a period input, compared with the 8-bit duty
`timescale 1ns/1ps
`default_nettype none
module lbd_dimming_top #(
  parameter int EN_LOW_CYCLES = lbd_pkg::LBD_EN_LOW_CYC,
  parameter int PERIOD_W      = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire lbd_pkg::lbd_reg_req_t reg_req,
  input  wire logic                 enable_pin,
  input  wire logic                 external_pwm_duty,
  input  wire logic                 direct_mode_pin,
  input  wire logic [PERIOD_W-1:0]  dimming_freq_set_pin,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  output logic [5:0]                led_channel_outputs,
  output logic [7:0]                current_cmd,
  output logic                      shutdown
);
  import lbd_pkg::*;

  // ==========================================================
  // pin synchronisers: three stages, a change counts when stages two and three agree
  logic [LBD_SYNC_PINS-1:0] pin_raw;
  logic [LBD_SYNC_PINS-1:0] s1;
  logic [LBD_SYNC_PINS-1:0] s2;
  logic [LBD_SYNC_PINS-1:0] s3;
  logic [LBD_SYNC_PINS-1:0] pin_f;
  logic [LBD_SYNC_PINS-1:0] next_pin_f;
  logic                     en_f;
  logic                     ext_f;
  logic                     direct_f;

  assign pin_raw  = {direct_mode_pin, external_pwm_duty, enable_pin};
  assign en_f     = pin_f[0];
  assign ext_f    = pin_f[1];
  assign direct_f = pin_f[2];

  genvar gi;
  generate
    for (gi = 0; gi < LBD_SYNC_PINS; gi++) begin : g_sync
      // filtered level holds until the two late stages agree
      always_comb begin
        next_pin_f[gi] = (s2[gi] == s3[gi]) ? s3[gi] : pin_f[gi];
      end
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1[gi]    <= 1'b0;
          s2[gi]    <= 1'b0;
          s3[gi]    <= 1'b0;
          pin_f[gi] <= 1'b0;
        end else begin
          s1[gi]    <= pin_raw[gi];
          s2[gi]    <= s1[gi];
          s3[gi]    <= s2[gi];
          pin_f[gi] <= next_pin_f[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // register file
  logic [7:0] brightness_level;
  logic [7:0] dimming_mode_select;
  logic [7:0] dc_current_level;
  logic [7:0] next_brightness;
  logic [7:0] next_mode;
  logic [7:0] next_dc;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // read mux used by the read path
  function automatic logic [7:0] reg_sel(input logic [7:0] a, input logic [7:0] b,
                                         input logic [7:0] m, input logic [7:0] d);
    case (a)
      LBD_ADDR_BRIGHT: reg_sel = b;
      LBD_ADDR_MODE:   reg_sel = m;
      LBD_ADDR_DC:     reg_sel = d;
      default:         reg_sel = 8'h00;  // unmapped reads return zero
    endcase
  endfunction

  // writes land on the next edge, also while shut down
  always_comb begin
    next_brightness = brightness_level;
    next_mode       = dimming_mode_select;
    next_dc         = dc_current_level;
    next_rvalid     = reg_req.rd;
    next_rdata      = reg_req.rd ? reg_sel(reg_req.addr, brightness_level,
                                           dimming_mode_select, dc_current_level) : 8'h00;
    if (reg_req.wr) begin
      case (reg_req.addr)
        LBD_ADDR_BRIGHT: next_brightness = reg_req.wdata;  // [RL12]
        LBD_ADDR_MODE:   next_mode       = reg_req.wdata;
        LBD_ADDR_DC:     next_dc         = reg_req.wdata;  // [RL2] [RL4]
        default:         next_mode       = dimming_mode_select;
      endcase
    end
  end

  // reset values select product mode and full scale
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brightness_level    <= LBD_RST_BRIGHT;  // [RL12]
      dimming_mode_select <= LBD_RST_MODE;    // [RL9] [RL15]
      dc_current_level    <= LBD_RST_DC;      // [RL2]
      reg_rdata           <= 8'h00;
      reg_rvalid          <= 1'b0;
    end else begin
      brightness_level    <= next_brightness;
      dimming_mode_select <= next_mode;
      dc_current_level    <= next_dc;
      reg_rdata           <= next_rdata;
      reg_rvalid          <= next_rvalid;
    end
  end

  // ==========================================================
  // enable watch: a low must outlast the full count before shutdown
  lbd_state_t state;
  lbd_state_t next_state;
  logic [21:0] low_cnt;
  logic [21:0] next_low_cnt;

  always_comb begin
    next_state   = state;
    next_low_cnt = low_cnt;
    case (state)
      LBD_ST_RUN: begin
        next_low_cnt = 22'h000000;
        if (!en_f) begin
          next_state = LBD_ST_LOW;
        end
      end
      LBD_ST_LOW: begin
        if (en_f) begin
          next_state = LBD_ST_RUN;  // short low pulse is ignored [RL1]
        end else if (low_cnt == 22'(EN_LOW_CYCLES - 1)) begin
          next_state = LBD_ST_OFF;  // [RL1]
        end else begin
          next_low_cnt = low_cnt + 22'h000001;
        end
      end
      LBD_ST_OFF: begin
        if (en_f) begin
          next_state = LBD_ST_RUN;
        end
      end
      default: next_state = LBD_ST_RUN;
    endcase
  end

  // starts in run so a held-high enable needs no wait after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state   <= LBD_ST_RUN;
      low_cnt <= 22'h000000;
    end else begin
      state   <= next_state;
      low_cnt <= next_low_cnt;
    end
  end

  // ==========================================================
  // dimming period: divider tick steps through 255 duty steps
  logic [PERIOD_W-1:0] div_cnt;
  logic [PERIOD_W-1:0] next_div;
  logic [7:0]          step;
  logic [7:0]          next_step;
  logic                tick;
  logic                frame_end;

  // a zero period input behaves as one so the tick never stops
  assign tick      = (div_cnt >= dimming_freq_set_pin - PERIOD_W'(1)) ||
                     (dimming_freq_set_pin == '0);  // [RL19]
  assign frame_end = tick && (step == LBD_STEP_LAST);

  always_comb begin
    next_div  = tick ? '0 : div_cnt + PERIOD_W'(1);
    next_step = step;
    if (tick) begin
      next_step = frame_end ? 8'h00 : step + 8'h01;  // [RL6]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      step    <= 8'h00;
    end else begin
      div_cnt <= next_div;
      step    <= next_step;
    end
  end

  // ==========================================================
  // external duty measurement
  logic [7:0] ext_duty;

  lbd_duty_meter u_meter (
    .mclk      (mclk),
    .rst       (rst),
    .tick      (tick),
    .frame_end (frame_end),
    .pwm_level (ext_f),
    .duty      (ext_duty)
  );

  // ==========================================================
  // duty select and channel gating
  logic [15:0] product;
  logic [7:0]  duty_sel;
  logic        gate;
  logic [5:0]  next_led;
  logic [7:0]  next_cur;

  assign product = ext_duty * brightness_level;  // [RL17]

  // unknown mode codes fall back to product, the reset behaviour
  always_comb begin
    case (dimming_mode_select)
      LBD_MODE_SERIAL: duty_sel = brightness_level;  // [RL11] [RL14]
      LBD_MODE_EXT:    duty_sel = ext_duty;          // [RL16]
      default:         duty_sel = product[15:8];     // [RL7] [RL9] [RL15]
    endcase
  end

  // step runs 0..254, so duty 255 is always on and duty 0 always off
  always_comb begin
    gate     = direct_f ? ext_f : (step < duty_sel);  // [RL8] [RL13]
    next_led = '0;
    next_cur = 8'h00;
    if (state != LBD_ST_OFF && dc_current_level != 8'h00 && gate) begin  // [RL1] [RL3]
      next_led = {LBD_CH_COUNT{1'b1}};  // [RL10]
      next_cur = dc_current_level;      // [RL5]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led_channel_outputs <= '0;
      current_cmd         <= 8'h00;
      shutdown            <= 1'b0;
    end else begin
      led_channel_outputs <= next_led;
      current_cmd         <= next_cur;
      shutdown            <= (next_state == LBD_ST_OFF);
    end
  end

  // ==========================================================
  // checks
  a_dc_zero_off: assert property (@(posedge mclk) disable iff (rst)  // [RL3]
    (dc_current_level == 8'h00) |=> (led_channel_outputs == 6'h00))
    else $error("channels on with zero dc level");

  a_off_dark: assert property (@(posedge mclk) disable iff (rst)  // [RL1]
    (state == LBD_ST_OFF) |=> (led_channel_outputs == 6'h00) && (shutdown == !$past(en_f)))
    else $error("channels on while shut down");

  a_short_low: assert property (@(posedge mclk) disable iff (rst)  // [RL1]
    (state == LBD_ST_LOW && en_f) |=> (state == LBD_ST_RUN) && !shutdown)
    else $error("short enable low caused shutdown");

  a_timeout_exact: assert property (@(posedge mclk) disable iff (rst)  // [RL1]
    (state == LBD_ST_LOW && !en_f && low_cnt == 22'(EN_LOW_CYCLES - 1)) |=> shutdown)
    else $error("no shutdown at end of enable timeout");

  a_dc_live: assert property (@(posedge mclk) disable iff (rst)  // [RL4]
    (reg_req.wr && reg_req.addr == LBD_ADDR_DC) |=> (dc_current_level == $past(reg_req.wdata)))
    else $error("dc level write not applied");

  a_bright_write: assert property (@(posedge mclk) disable iff (rst)  // [RL12]
    (reg_req.wr && reg_req.addr == LBD_ADDR_BRIGHT) |=> (brightness_level == $past(reg_req.wdata)))
    else $error("brightness write not applied");

  a_cur_scale: assert property (@(posedge mclk) disable iff (rst)  // [RL5]
    (led_channel_outputs != 6'h00) |-> (current_cmd == $past(dc_current_level)))
    else $error("current command not tied to dc level");

  a_all_equal: assert property (@(posedge mclk) disable iff (rst)  // [RL10]
    (led_channel_outputs == 6'h00) || (led_channel_outputs == 6'h3f))
    else $error("channels gated apart");

  a_direct_follow: assert property (@(posedge mclk) disable iff (rst)  // [RL8]
    (direct_f && state != LBD_ST_OFF && dc_current_level != 8'h00)
      |=> (led_channel_outputs == {6{$past(ext_f)}}))
    else $error("direct mode not following input");

  a_serial_only: assert property (@(posedge mclk) disable iff (rst)  // [RL14]
    (!direct_f && dimming_mode_select == LBD_MODE_SERIAL && state != LBD_ST_OFF &&
     dc_current_level != 8'h00) |=> (led_channel_outputs[0] == $past(step < brightness_level)))
    else $error("serial mode not following brightness");

  c_shutdown:  cover property (@(posedge mclk) disable iff (rst) $rose(shutdown));
  c_product:   cover property (@(posedge mclk) disable iff (rst)
    dimming_mode_select == LBD_MODE_PRODUCT && led_channel_outputs != 6'h00);
  c_direct:    cover property (@(posedge mclk) disable iff (rst) direct_f && $rose(led_channel_outputs[0]));
  c_dc_change: cover property (@(posedge mclk) disable iff (rst)
    reg_req.wr && reg_req.addr == LBD_ADDR_DC && led_channel_outputs != 6'h00);

endmodule
`default_nettype wire

// [verif/lbd_pwm_source.sv]
// external pwm source model for the backlight dimming bench
// assumes one clock shared with the block; lengths are in clock cycles
`timescale 1ns/1ps
`default_nettype none
module lbd_pwm_source (
  input  wire logic        mclk,
  input  wire logic [15:0] high_len,
  input  wire logic [15:0] low_len,
  output logic             pwm
);
  int cnt = 0;
  // ==========================================================
  // waveform: changes after the falling edge so sampling never races it
  // a zero low length holds the line high; lows stay far below shutdown span
  always @(negedge mclk) begin
    if (low_len == 16'h0000) begin
      pwm <= 1'b1;
      cnt <= 0;
    end else if (pwm && cnt + 1 >= int'(high_len)) begin
      pwm <= 1'b0;
      cnt <= 0;
    end else if (!pwm && cnt + 1 >= int'(low_len)) begin
      pwm <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the backlight dimming block
// assumes lbd_pkg and the pwm source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lbd_pkg::*;
  // ==========================================================
  // signals
  logic         mclk  = 1'b0;
  logic         rst   = 1'b1;
  lbd_reg_req_t req   = '0;
  logic         en    = 1'b1;
  logic         dmode = 1'b0;
  logic [15:0]  hi    = 16'd1;
  logic [15:0]  lo    = 16'd0;
  logic [15:0]  per   = 16'h0001;
  logic         ext;
  logic [7:0]   rdata;
  logic [7:0]   cmd;
  logic         rvalid;
  logic         sd;
  logic [5:0]   leds;
  logic [7:0]   addrs[3];
  int           n_fail      = 0;
  int           comparisons = 0;
  int           dc_m        = 255;
  int           b;
  int           hits;
  int           bq[$]       = '{0, 1, 128, 255};

  // short enable count keeps the shutdown test brief
  lbd_dimming_top #(.EN_LOW_CYCLES(50), .PERIOD_W(16)) i_dut (
    .mclk(mclk), .rst(rst), .reg_req(req), .enable_pin(en),
    .external_pwm_duty(ext), .direct_mode_pin(dmode),
    .dimming_freq_set_pin(per), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .led_channel_outputs(leds), .current_cmd(cmd), .shutdown(sd));

  lbd_pwm_source i_src (.mclk(mclk), .high_len(hi), .low_len(lo), .pwm(ext));

  initial forever #5 mclk = ~mclk;

  // ==========================================================
  // reference model and helpers
  function automatic int exp_on(input int md, input int br, input int h);
    if (md == 3) return h;
    if (md == 5) return br;
    return (h * br) >> 8;  // top byte of the product, so 255*255 gives 254
  endfunction

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] e);
    comparisons++;
    if (got !== e) begin
      n_fail++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, e);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int k;
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    req = '0;
    for (k = 0; k < 3 && rvalid !== 1'b1; k++) @(negedge mclk);
    check("read valid", {31'h0, rvalid}, 32'h1);
    check("read data", {24'h0, rdata}, {24'h0, e});
  endtask

  // settle 765 cycles (three dimming periods at period input one), then count on-cycles over one window
  task automatic measure(input int e, input int win);
    int n;
    int bad;
    n = 0;
    bad = 0;
    repeat (765) @(negedge mclk);
    repeat (win) begin
      @(negedge mclk);
      if (leds === 6'h3f) n++;
      else if (leds !== 6'h00) bad++;
      if (cmd !== (leds[0] ? 8'(dc_m) : 8'h00)) bad++;
    end
    check("on count", n, e);
    check("gating", bad, 0);
  endtask

  // ==========================================================
  // watchdog: whole sequence needs about 14k cycles
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hb423c65c));
    addrs = '{LBD_ADDR_BRIGHT, LBD_ADDR_MODE, LBD_ADDR_DC};
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    rd(LBD_ADDR_BRIGHT, LBD_RST_BRIGHT);
    rd(LBD_ADDR_MODE, LBD_RST_MODE);
    rd(LBD_ADDR_DC, LBD_RST_DC);
    // ext input held high in product mode takes brightness 255 down to 254 on-cycles
    measure(exp_on(1, 255, 255), 255);
    foreach (addrs[i]) begin
      b = $urandom_range(255);
      wr(addrs[i], 8'(b));
      rd(addrs[i], 8'(b));
    end
    wr(8'h02, 8'h5a);
    rd(8'h02, 8'h00);
    wr(LBD_ADDR_DC, 8'hff);
    // serial mode while the ext input toggles: it must be ignored
    hi <= 16'd60;
    lo <= 16'd195;
    wr(LBD_ADDR_MODE, LBD_MODE_SERIAL);
    bq.push_back($urandom_range(2, 254));
    foreach (bq[i]) begin
      wr(LBD_ADDR_BRIGHT, 8'(bq[i]));
      measure(exp_on(5, bq[i], 60), 255);
    end
    // dc level changed on the fly, then zero
    dc_m = $urandom_range(1, 254);
    wr(LBD_ADDR_DC, 8'(dc_m));
    measure(exp_on(5, bq[4], 60), 255);
    dc_m = 0;
    wr(LBD_ADDR_DC, 8'h00);
    measure(0, 255);
    dc_m = 255;
    wr(LBD_ADDR_DC, 8'hff);
    wr(LBD_ADDR_MODE, LBD_MODE_EXT);
    measure(exp_on(3, bq[4], 60), 255);
    // product mode with both factors random
    b = $urandom_range(1, 255);
    hits = $urandom_range(1, 254);
    hi <= 16'(hits);
    lo <= 16'(255 - hits);
    wr(LBD_ADDR_BRIGHT, 8'(b));
    wr(LBD_ADDR_MODE, LBD_MODE_PRODUCT);
    measure(exp_on(1, b, hits), 255);
    // direct mode follows a faster ext waveform
    hi <= 16'd37;
    lo <= 16'd100;
    dmode <= 1'b1;
    measure(37, 137);
    dmode <= 1'b0;
    // dimming period follows the period input; zero behaves as one
    b = $urandom_range(1, 254);
    wr(LBD_ADDR_MODE, LBD_MODE_SERIAL);
    wr(LBD_ADDR_BRIGHT, 8'(b));
    per <= 16'h0003;
    measure(3 * exp_on(5, b, 0), 765);
    per <= 16'h0000;
    measure(exp_on(5, b, 0), 255);
    per <= 16'h0001;
    // short enable low, well under the 50-cycle count, must not shut down
    hits = 0;
    en <= 1'b0;
    repeat ($urandom_range(20, 45)) begin
      @(negedge mclk);
      if (sd !== 1'b0) hits++;
    end
    en <= 1'b1;
    repeat (10) begin
      @(negedge mclk);
      if (sd !== 1'b0) hits++;
    end
    check("short low", hits, 0);
    // a long low: still running before the count ends, shut down after it
    en <= 1'b0;
    repeat (50) @(negedge mclk);
    check("no early shutdown", {31'h0, sd}, 32'h0);
    repeat (20) @(negedge mclk);
    check("shutdown", {31'h0, sd}, 32'h1);
    check("outputs off", {26'h0, leds}, 32'h0);
    en <= 1'b1;
    repeat (10) @(negedge mclk);
    check("restart", {31'h0, sd}, 32'h0);
    // second reset in mid-run brings every register back to its default
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    rd(LBD_ADDR_BRIGHT, LBD_RST_BRIGHT);
    rd(LBD_ADDR_MODE, LBD_RST_MODE);
    rd(LBD_ADDR_DC, LBD_RST_DC);
    end_sim();
  end
endmodule
`default_nettype wire
